/* File: hw/burner_prepurge_sequencer.sv */
// Startup check and proven pre-purge sequencer with APB registers
//
// Contract
// [RQ1] Waiting to startup checks only with channel on, no alarm or wait.
// [RQ2] Channel option disabled: startup checks skipped, never entered.
// [RQ3] Startup checks keep safety outputs off, ignition enable contact open.
// [RQ4] Airflow seen before the fan runs in startup checks causes lockout.
// [RQ5] Alarm or stop locks out; wait condition returns to waiting.
// [RQ6] No airflow, alarm or wait in startup checks: request purge position.
// [RQ7] Request purge position drives every channel to its purge position.
// [RQ8] Unproven purge position locks out; proven advances to prove airflow.
// [RQ9] Prove airflow energizes the fan and waits for airflow.
// [RQ10] Prove airflow: unproven airflow or position locks out, else advances.
// [RQ11] Pre-purge keeps fan on and channels at purge positions throughout.
// [RQ12] Airflow lost at any time in pre-purge causes lockout.
// [RQ13] Purge position lost at any time in pre-purge causes lockout.
// [RQ14] Pre-purge done: request pilot position if enabled, else ignition.
// [RQ15] All pre-purge sub-states keep safety outputs off, contact open.
// [RQ16] Pre-purge counter loaded from set duration; done only while proven.
//
// Added by the designer: the register offsets and the APB interface to the registers.
module burner_prepurge_sequencer
    import prepurge_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ALARM,
    input wire logic WAIT_COND,
    input wire logic USER_STOP,
    input wire logic AIRFLOW_PROVEN,
    input wire logic POSITION_PROVEN,
    output logic FAN_OUTPUT,
    output logic [NUM_CHANNELS*POS_W-1:0] AIR_FUEL_CHANNEL_POS,
    output logic AIR_FUEL_CHANNEL_DRIVE,
    output logic PILOT_OUTPUT,
    output logic MAIN_SAFETY_VALVE_ONE,
    output logic MAIN_SAFETY_VALVE_TWO,
    output logic PILOT_VALVE,
    output logic IGNITION_COIL,
    output logic IGNITION_ENABLE_CLOSED,
    output logic PILOT_POS_REQUEST,
    output logic IGNITION_REQUEST,
    output logic LOCKOUT,
    output logic IRQ
);
    // Pins are asynchronous to CLK
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic alarm, wait_c, stop, airflow, pos_ok, fault;

    logic afc_en, run, lock_clr;
    logic [31:0] purge_time, prove_timeout, purge_pos;
    logic [IRQ_W-1:0] irq_status, irq_mask, irq_event;
    logic [31:0] timer;
    logic timer_zero, purge_done;
    seq_state_t state, next_state;
    logic wr_en, rd_en;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {POSITION_PROVEN, AIRFLOW_PROVEN, USER_STOP, WAIT_COND,
                      ALARM};
            sync2 <= sync1;
        end
    end

    assign alarm = sync2[IN_ALARM];
    assign wait_c = sync2[IN_WAIT];
    assign stop = sync2[IN_STOP];
    assign airflow = sync2[IN_AIRFLOW];
    assign pos_ok = sync2[IN_POSITION];
    assign fault = alarm | stop;

    // APB: zero wait states, error on unmapped offsets
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & ~PENABLE & ~PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~(PADDR == OFS_CTRL
        || PADDR == OFS_PURGE_TIME || PADDR == OFS_PURGE_POS
        || PADDR == OFS_STATUS || PADDR == OFS_IRQ_STATUS
        || PADDR == OFS_IRQ_MASK || PADDR == OFS_PROVE_TIMEOUT);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            afc_en <= 1'b0;
            run <= 1'b0;
            lock_clr <= 1'b0;
            purge_time <= PURGE_TIME_RST;
            prove_timeout <= PROVE_TIMEOUT_RST;
            purge_pos <= PURGE_POS_RST;
            irq_mask <= IRQ_MASK_RST;
        end else begin
            lock_clr <= 1'b0;
            if (wr_en && PADDR == OFS_CTRL) begin
                afc_en <= PWDATA[CTRL_AFC_EN];
                run <= PWDATA[CTRL_RUN];
                lock_clr <= PWDATA[CTRL_LOCK_CLR];
            end else if (wr_en && PADDR == OFS_PURGE_TIME) begin
                purge_time <= PWDATA;
            end else if (wr_en && PADDR == OFS_PURGE_POS) begin
                purge_pos <= PWDATA;
            end else if (wr_en && PADDR == OFS_IRQ_MASK) begin
                irq_mask <= PWDATA[IRQ_W-1:0];
            end else if (wr_en && PADDR == OFS_PROVE_TIMEOUT) begin
                prove_timeout <= PWDATA;
            end
        end
    end

    // Read data captured in setup so it stands through the access phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            if (PADDR == OFS_CTRL) begin
                PRDATA <= {30'h0, run, afc_en};
            end else if (PADDR == OFS_PURGE_TIME) begin
                PRDATA <= purge_time;
            end else if (PADDR == OFS_PURGE_POS) begin
                PRDATA <= purge_pos;
            end else if (PADDR == OFS_STATUS) begin
                PRDATA <= {19'h0, sync2, 4'h0, state};
            end else if (PADDR == OFS_IRQ_STATUS) begin
                PRDATA <= {29'h0, irq_status};
            end else if (PADDR == OFS_IRQ_MASK) begin
                PRDATA <= {29'h0, irq_mask};
            end else if (PADDR == OFS_PROVE_TIMEOUT) begin
                PRDATA <= prove_timeout;
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // Sequencer
    assign timer_zero = (timer == 32'h0000_0000);
    assign purge_done = (state == ST_PRE_PURGE) && timer_zero && airflow
        && pos_ok; // RQ16

    always_comb begin
        next_state = state;
        case (state)
            ST_WAITING: begin
                if (fault) begin
                    next_state = ST_LOCKOUT; // RQ5
                end else if (run && !wait_c) begin
                    // Disabled channel option never passes startup checks
                    next_state = afc_en ? ST_STARTUP : ST_IGNITION; // RQ1 RQ2
                end
            end
            ST_STARTUP: begin
                if (fault || airflow) begin
                    next_state = ST_LOCKOUT; // RQ4 RQ5
                end else if (wait_c) begin
                    next_state = ST_WAITING; // RQ5
                end else begin
                    next_state = ST_REQ_PURGE; // RQ6
                end
            end
            ST_REQ_PURGE: begin
                if (fault || (timer_zero && !pos_ok)) begin
                    next_state = ST_LOCKOUT; // RQ5 RQ8
                end else if (wait_c) begin
                    next_state = ST_WAITING; // RQ5
                end else if (pos_ok) begin
                    next_state = ST_PROVE_AIR; // RQ8
                end
            end
            ST_PROVE_AIR: begin
                if (fault || !pos_ok || (timer_zero && !airflow)) begin
                    next_state = ST_LOCKOUT; // RQ5 RQ10
                end else if (wait_c) begin
                    next_state = ST_WAITING; // RQ5
                end else if (airflow) begin
                    next_state = ST_PRE_PURGE; // RQ10
                end
            end
            ST_PRE_PURGE: begin
                if (fault || !airflow || !pos_ok) begin
                    next_state = ST_LOCKOUT; // RQ5 RQ12 RQ13
                end else if (wait_c) begin
                    next_state = ST_WAITING; // RQ5
                end else if (purge_done) begin
                    next_state = afc_en ? ST_REQ_PILOT : ST_IGNITION; // RQ14
                end
            end
            ST_REQ_PILOT, ST_IGNITION: begin
                // Hand-off states; later phases live elsewhere
                if (fault) begin
                    next_state = ST_LOCKOUT;
                end else if (wait_c) begin
                    next_state = ST_WAITING;
                end
            end
            ST_LOCKOUT: begin
                // Needs an explicit software reset, never self-clears
                if (lock_clr && !alarm) begin
                    next_state = ST_WAITING;
                end
            end
            default: next_state = ST_LOCKOUT;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_WAITING;
        end else begin
            state <= next_state;
        end
    end

    // One timer serves the prove timeouts and the purge duration
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            timer <= 32'h0000_0000;
        end else if (next_state != state) begin
            if (next_state == ST_PRE_PURGE) begin
                timer <= purge_time; // RQ16
            end else begin
                timer <= prove_timeout;
            end
        end else if (!timer_zero) begin
            timer <= timer - 32'h0000_0001;
        end
    end

    // Outputs follow the state being entered, so they change with it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FAN_OUTPUT <= 1'b0;
            AIR_FUEL_CHANNEL_DRIVE <= 1'b0;
            PILOT_POS_REQUEST <= 1'b0;
            IGNITION_REQUEST <= 1'b0;
            LOCKOUT <= 1'b0;
        end else begin
            FAN_OUTPUT <= next_state == ST_PROVE_AIR
                || next_state == ST_PRE_PURGE
                || next_state == ST_REQ_PILOT; // RQ9 RQ11
            AIR_FUEL_CHANNEL_DRIVE <= next_state == ST_REQ_PURGE
                || next_state == ST_PROVE_AIR
                || next_state == ST_PRE_PURGE; // RQ7 RQ11
            PILOT_POS_REQUEST <= next_state == ST_REQ_PILOT;
            IGNITION_REQUEST <= next_state == ST_IGNITION;
            LOCKOUT <= next_state == ST_LOCKOUT;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    AIR_FUEL_CHANNEL_POS[ch*POS_W +: POS_W] <= '0;
                end else if (next_state == ST_REQ_PURGE
                    || next_state == ST_PROVE_AIR
                    || next_state == ST_PRE_PURGE) begin
                    AIR_FUEL_CHANNEL_POS[ch*POS_W +: POS_W] <=
                        purge_pos[ch*POS_W +: POS_W]; // RQ7 RQ11
                end else begin
                    AIR_FUEL_CHANNEL_POS[ch*POS_W +: POS_W] <= '0;
                end
            end
        end
    endgenerate

    // Fuel and ignition are never energised by this phase
    assign PILOT_OUTPUT = 1'b0; // RQ3 RQ15
    assign MAIN_SAFETY_VALVE_ONE = 1'b0; // RQ3 RQ15
    assign MAIN_SAFETY_VALVE_TWO = 1'b0; // RQ3 RQ15
    assign PILOT_VALVE = 1'b0; // RQ3 RQ15
    assign IGNITION_COIL = 1'b0; // RQ3 RQ15
    assign IGNITION_ENABLE_CLOSED = 1'b0; // RQ3 RQ15

    // Interrupts: set beats write-one-to-clear
    assign irq_event[IRQ_LOCKOUT] = next_state == ST_LOCKOUT
        && state != ST_LOCKOUT;
    assign irq_event[IRQ_WAITING] = next_state == ST_WAITING
        && state != ST_WAITING && state != ST_LOCKOUT;
    assign irq_event[IRQ_PURGE_DONE] = purge_done && next_state != ST_LOCKOUT
        && next_state != ST_WAITING;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= '0;
        end else if (wr_en && PADDR == OFS_IRQ_STATUS) begin
            irq_status <= (irq_status & ~PWDATA[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    assign IRQ = |(irq_status & irq_mask);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_start_gate: // RQ1
    assert property (state == ST_STARTUP && $past(state) == ST_WAITING
        |-> $past(afc_en) && !$past(alarm) && !$past(wait_c))
    else $error("startup checks entered without permission");

    a_skip_checks: // RQ2
    assert property (!afc_en |=> state != ST_STARTUP)
    else $error("startup checks entered with option disabled");

    a_safety_dark: // RQ3
    assert property (state inside {ST_STARTUP, ST_REQ_PURGE, ST_PROVE_AIR,
        ST_PRE_PURGE} |-> !PILOT_OUTPUT && !MAIN_SAFETY_VALVE_ONE
        && !MAIN_SAFETY_VALVE_TWO && !PILOT_VALVE && !IGNITION_COIL
        && !IGNITION_ENABLE_CLOSED && !IGNITION_REQUEST)
    else $error("safety output energised during pre-purge");

    a_stuck_sensor: // RQ4
    assert property (state == ST_STARTUP && airflow |=> state == ST_LOCKOUT
        ##1 LOCKOUT)
    else $error("stuck airflow sensor not locked out");

    a_fault_lockout: // RQ5
    assert property (state inside {ST_STARTUP, ST_REQ_PURGE, ST_PROVE_AIR,
        ST_PRE_PURGE} && fault |=> state == ST_LOCKOUT)
    else $error("alarm or stop did not lock out");

    a_purge_drive: // RQ7
    assert property (state == ST_PROVE_AIR |-> AIR_FUEL_CHANNEL_DRIVE
        && AIR_FUEL_CHANNEL_POS == purge_pos)
    else $error("channels not at purge position");

    a_fan_on: // RQ9
    assert property (state == ST_REQ_PURGE ##1 state == ST_PROVE_AIR
        |-> FAN_OUTPUT && !$past(FAN_OUTPUT))
    else $error("fan not energised with prove airflow");

    a_air_drop: // RQ12
    assert property (state == ST_PRE_PURGE && !airflow |=> state == ST_LOCKOUT)
    else $error("airflow loss in pre-purge not locked out");

    a_pos_drop: // RQ13
    assert property (state == ST_PRE_PURGE && !pos_ok |=> state == ST_LOCKOUT)
    else $error("position loss in pre-purge not locked out");

    a_wait_exit: // RQ5
    assert property (state inside {ST_STARTUP, ST_REQ_PURGE, ST_PROVE_AIR,
        ST_PRE_PURGE} && wait_c |=> state inside {ST_WAITING, ST_LOCKOUT})
    else $error("wait condition did not stop the sequence");

    a_position_fail: // RQ8
    assert property (state == ST_REQ_PURGE && timer_zero && !pos_ok
        |=> state == ST_LOCKOUT)
    else $error("unproven purge position not locked out");

    a_prove_fail: // RQ10
    assert property (state == ST_PROVE_AIR && (!pos_ok || (timer_zero
        && !airflow)) |=> state == ST_LOCKOUT)
    else $error("unproven airflow or position not locked out");

    a_purge_exit: // RQ14
    assert property (purge_done && !fault && !wait_c
        |=> state == ($past(afc_en) ? ST_REQ_PILOT : ST_IGNITION))
    else $error("wrong exit after pre-purge");

    a_purge_load: // RQ16
    assert property (state == ST_PRE_PURGE && $past(state) != ST_PRE_PURGE
        |-> timer == $past(purge_time))
    else $error("purge timer not loaded");

    c_to_pilot: cover property (state == ST_PRE_PURGE
        ##1 state == ST_REQ_PILOT);
    c_stuck: cover property (state == ST_STARTUP ##1 state == ST_LOCKOUT);
    c_skip: cover property (state == ST_WAITING ##1 state == ST_IGNITION);
    c_air_lost: cover property (state == ST_PRE_PURGE ##1 state == ST_LOCKOUT);
    c_to_wait: cover property (state == ST_PROVE_AIR ##1 state == ST_WAITING);
endmodule

/* File: hw/prepurge_pkg.sv */
// Constants and types for the burner pre-purge sequencer
package prepurge_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int NUM_CHANNELS = 4;
    localparam int POS_W = 8;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PURGE_TIME = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PURGE_POS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PROVE_TIMEOUT = 8'h18;

    // Control fields
    localparam int CTRL_AFC_EN = 0;
    localparam int CTRL_RUN = 1;
    localparam int CTRL_LOCK_CLR = 2;

    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_STATE_W = 4;
    localparam int STAT_IN_LSB = 8;

    // Interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCKOUT = 0;
    localparam int IRQ_WAITING = 1;
    localparam int IRQ_PURGE_DONE = 2;

    // Synchronised input bit positions
    localparam int IN_W = 5;
    localparam int IN_ALARM = 0;
    localparam int IN_WAIT = 1;
    localparam int IN_STOP = 2;
    localparam int IN_AIRFLOW = 3;
    localparam int IN_POSITION = 4;

    // Reset values, counts in clock cycles
    localparam logic [31:0] PURGE_TIME_RST = 32'h0000_1000;
    localparam logic [31:0] PROVE_TIMEOUT_RST = 32'h0000_0400;
    localparam logic [31:0] PURGE_POS_RST = 32'hFFFF_FFFF;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [3:0] {
        ST_WAITING,
        ST_STARTUP,
        ST_REQ_PURGE,
        ST_PROVE_AIR,
        ST_PRE_PURGE,
        ST_REQ_PILOT,
        ST_IGNITION,
        ST_LOCKOUT
    } seq_state_t;
endpackage

/* File: sim/plant_model.sv */
// Plant model: fan, airflow switch and damper positioners
module plant_model
    import prepurge_pkg::*;
#(
    parameter int AIR_DLY = 3
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fan_on,
    input wire logic drive_on,
    input wire logic stuck_air,
    input wire logic no_air,
    input wire logic no_pos,
    output logic air_ok,
    output logic pos_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [AIR_DLY-1:0] spin;
    logic moved;

    // Fan needs a few cycles to spin up before the switch closes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spin <= '0;
            moved <= 1'b0;
        end else begin
            spin <= {spin[AIR_DLY-2:0], fan_on};
            moved <= drive_on;
        end
    end

    // A welded switch shows airflow even with the fan off
    assign air_ok = stuck_air | (spin[AIR_DLY-1] & !no_air);
    assign pos_ok = moved & !no_pos;
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the pre-purge sequencer
module tb
    import prepurge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AIR_DLY = 3;
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, serr;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, pos_exp;
    logic ALARM, WAIT_COND, USER_STOP, AIRFLOW_PROVEN, POSITION_PROVEN;
    logic FAN_OUTPUT, AIR_FUEL_CHANNEL_DRIVE, PILOT_OUTPUT, PILOT_VALVE;
    logic MAIN_SAFETY_VALVE_ONE, MAIN_SAFETY_VALVE_TWO, IGNITION_COIL;
    logic IGNITION_ENABLE_CLOSED, PILOT_POS_REQUEST, IGNITION_REQUEST;
    logic LOCKOUT, IRQ, stuck_air, no_air, no_pos, saw_drive;
    logic [NUM_CHANNELS*POS_W-1:0] AIR_FUEL_CHANNEL_POS;
    logic [4:0] obs;
    int failures, n_checks, seed, pt, k, n;
    // Fault table: late, expect lockout, {stop,wait,alarm,pos,air,stuck}
    logic [7:0] plan [8] = '{8'h41, 8'h44, 8'h42, 8'hC2, 8'hC4, 8'hC8,
                             8'hE0, 8'h90};
    logic [ADDR_W-1:0] regs [5] = '{OFS_CTRL, OFS_PURGE_TIME, OFS_PURGE_POS,
                                    OFS_IRQ_MASK, OFS_PROVE_TIMEOUT};
    logic [31:0] rsts [5] = '{32'h0, PURGE_TIME_RST, PURGE_POS_RST,
                              {29'h0, IRQ_MASK_RST}, PROVE_TIMEOUT_RST};

    assign obs = {IGNITION_REQUEST, PILOT_POS_REQUEST, LOCKOUT, FAN_OUTPUT,
                  AIR_FUEL_CHANNEL_DRIVE};

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    burner_prepurge_sequencer burner_prepurge_sequencer_inst (
        .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .ALARM(ALARM),
        .WAIT_COND(WAIT_COND), .USER_STOP(USER_STOP),
        .AIRFLOW_PROVEN(AIRFLOW_PROVEN), .POSITION_PROVEN(POSITION_PROVEN),
        .FAN_OUTPUT(FAN_OUTPUT), .AIR_FUEL_CHANNEL_POS(AIR_FUEL_CHANNEL_POS),
        .AIR_FUEL_CHANNEL_DRIVE(AIR_FUEL_CHANNEL_DRIVE),
        .PILOT_OUTPUT(PILOT_OUTPUT),
        .MAIN_SAFETY_VALVE_ONE(MAIN_SAFETY_VALVE_ONE),
        .MAIN_SAFETY_VALVE_TWO(MAIN_SAFETY_VALVE_TWO),
        .PILOT_VALVE(PILOT_VALVE), .IGNITION_COIL(IGNITION_COIL),
        .IGNITION_ENABLE_CLOSED(IGNITION_ENABLE_CLOSED),
        .PILOT_POS_REQUEST(PILOT_POS_REQUEST),
        .IGNITION_REQUEST(IGNITION_REQUEST), .LOCKOUT(LOCKOUT), .IRQ(IRQ));

    plant_model #(.AIR_DLY(AIR_DLY)) plant_model_inst (
        .clk(CLK), .rst_n(RST_N), .fan_on(FAN_OUTPUT),
        .drive_on(AIR_FUEL_CHANNEL_DRIVE), .stuck_air(stuck_air),
        .no_air(no_air), .no_pos(no_pos), .air_ok(AIRFLOW_PROVEN),
        .pos_ok(POSITION_PROVEN));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Fan edge to pilot request: spin-up, two sync edges, one state edge,
    // then a pre-purge of t + 1 cycles
    function automatic int purge_cycles(input int t);
        return t + AIR_DLY + 4;
    endfunction

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (i == 50) begin
            failures++;
            $display("ERROR at %0t: no ready from register bus", $time);
            tally_and_finish();
        end
        rd = PRDATA;
        serr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        #1;
    endtask

    task automatic apply(input logic [5:0] f);
        @(posedge CLK);
        {USER_STOP, WAIT_COND, ALARM, no_pos, no_air, stuck_air} <= f;
    endtask

    // Bounded wait; n keeps the cycle count for timing checks
    task automatic wait_obs(input int b, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge CLK);
            #1;
            if (obs[b] === 1'b1) return;
        end
        failures++;
        $display("ERROR at %0t: output %0d never rose", $time, b);
        tally_and_finish();
    endtask

    // Short of an alarm or stop, a wait condition is the only way out of the hand-off states
    task automatic recover;
        apply(6'h10);
        repeat (4) @(posedge CLK);
        apb(1'b1, OFS_CTRL, 32'h4);
        apply(6'h00);
        repeat (4) @(posedge CLK);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, ST_WAITING});
    endtask

    always @(posedge CLK) begin
        #1;
        if (RST_N === 1'b1) begin
            chk({26'h0, PILOT_OUTPUT, MAIN_SAFETY_VALVE_ONE, PILOT_VALVE,
                 MAIN_SAFETY_VALVE_TWO, IGNITION_COIL,
                 IGNITION_ENABLE_CLOSED}, 32'h0);
            if (AIR_FUEL_CHANNEL_DRIVE === 1'b1)
                chk(AIR_FUEL_CHANNEL_POS, pos_exp);
            if (FAN_OUTPUT === 1'b1 && PILOT_POS_REQUEST !== 1'b1)
                chk({31'h0, AIR_FUEL_CHANNEL_DRIVE}, 32'h1);
            if (AIR_FUEL_CHANNEL_DRIVE === 1'b1)
                saw_drive = 1'b1;
        end
    end

    initial begin
        seed = 6;
        failures = 0;
        n_checks = 0;
        saw_drive = 1'b0;
        pos_exp = 32'h0;
        {PSEL, PENABLE, PWRITE, RST_N} = 4'h0;
        PADDR = '0;
        PWDATA = 32'h0;
        {USER_STOP, WAIT_COND, ALARM, no_pos, no_air, stuck_air} = 6'h00;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        for (k = 0; k < 5; k++) begin
            apb(1'b0, regs[k], 32'h0);
            chk(rd, rsts[k]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, serr}, 32'h1);
        $display("test register reset done");
        pt = 8 + ($random(seed) & 15);
        pos_exp = $random(seed);
        apb(1'b1, OFS_PURGE_TIME, 32'(pt));
        apb(1'b1, OFS_PROVE_TIMEOUT, 32'd20);
        apb(1'b1, OFS_PURGE_POS, pos_exp);
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        // Held back while a wait condition stands
        apply(6'h10);
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (8) @(posedge CLK);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, ST_WAITING});
        apply(6'h00);
        wait_obs(1, 200);
        wait_obs(3, 200);
        chk({31'h0, FAN_OUTPUT}, 32'h1);
        chk(32'(n), 32'(purge_cycles(pt)));
        chk({31'h0, IRQ}, 32'h1);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        chk({31'h0, IRQ}, 32'h0);
        recover();
        $display("test normal purge done");
        saw_drive = 1'b0;
        apb(1'b1, OFS_CTRL, 32'h2);
        wait_obs(4, 50);
        chk({31'h0, saw_drive}, 32'h0);
        recover();
        $display("test channel disabled done");
        for (k = 0; k < 8; k++) begin
            apply(plan[k][7] ? 6'h00 : plan[k][5:0]);
            repeat (4) @(posedge CLK);
            apb(1'b1, OFS_CTRL, 32'h3);
            if (plan[k][7]) begin
                wait_obs(1, 200);
                repeat (AIR_DLY + 4 + ($random(seed) & 3)) @(posedge CLK);
                apply(plan[k][5:0]);
            end
            if (plan[k][6]) begin
                wait_obs(2, 100);
                chk({31'h0, IRQ}, 32'h1);
            end else begin
                repeat (8) @(posedge CLK);
                apb(1'b0, OFS_STATUS, 32'h0);
                chk({28'h0, rd[3:0]}, {28'h0, ST_WAITING});
                chk({30'h0, LOCKOUT, IRQ}, 32'h0);
                apb(1'b0, OFS_IRQ_STATUS, 32'h0);
                chk(rd & 32'h7, 32'h2);
            end
            chk({31'h0, PILOT_POS_REQUEST}, 32'h0);
            recover();
            $display("test fault case %0d done", k);
        end
        tally_and_finish();
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
endmodule
